//--- logic/baud_divider_counter.sv
// One 8-bit divider counter of the baud generator, with the halving stage
`timescale 1ns/100ps

module baud_divider_counter
    import uart_bpf_pkg::*;
(
    input  wire logic             clk_sys_i,
    input  wire logic             sys_rst_i,
    input  wire logic             run_i,
    input  wire logic             restart_i,
    input  wire logic             base_tick_i,
    input  wire logic [DIV_W-1:0] divisor_k_i,
    output logic                  div_tick_o,
    output logic                  bit_tick_o
);

    typedef struct packed {
        logic [DIV_W-1:0] cnt;
        logic             half;
        logic             div_tick;
        logic             bit_tick;
    } div_s;

    div_s st;
    div_s next_st;

    // ****************************************
    // Counter
    // ****************************************
    // Reload on terminal count; a restart realigns the phase to the start bit
    always_comb begin
        next_st          = st;
        next_st.div_tick = 1'b0;
        next_st.bit_tick = 1'b0;
        if (!run_i || restart_i) begin
            next_st.cnt  = divisor_k_i;
            next_st.half = 1'b0;
        end else if (base_tick_i) begin
            if (st.cnt <= 8'h01) begin
                next_st.cnt      = divisor_k_i;
                next_st.div_tick = 1'b1;
                next_st.half     = ~st.half;
                next_st.bit_tick = st.half;
            end else begin
                next_st.cnt = st.cnt - 8'h01;
            end
        end
    end

    // State register
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            st <= '{cnt: DIV_RESET, half: 1'b0, div_tick: 1'b0, bit_tick: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign div_tick_o = st.div_tick;
    assign bit_tick_o = st.bit_tick;

    // ****************************************
    // Checks
    // ****************************************
    restart_reload_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        restart_i |=> (st.cnt == $past(divisor_k_i)) && !st.half)
        else $error("counter did not reload on restart");

    bit_halving_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        bit_tick_o |-> div_tick_o && !st.half)
        else $error("bit tick not on every second divider output");

endmodule

//--- logic/uart_baud_parity_filter.sv
// Baud generator, receive noise filter and parity logic of one serial channel
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/100ps

// Contract
// - Odd mode: even ones count flags error
// - Zero mode: transmitted parity bit always 0
// - Zero mode: receiver never flags parity error
// - No parity: omit bit, never flag
// - Filter updates after two equal base samples
// - Filtered input lags line up to two
// - Separate 8-bit transmit and receive dividers
// - Base clock only while channel enabled
// - Select code: fxx/2^n, 1011 external
// - Counters divide base clock by k
// - Baud rate is counter output halved
// - Reset: divisor all ones, select zero
// - Even mode: odd ones count flags error
// - Transmit parity makes total even/odd
module uart_baud_parity_filter
    import uart_bpf_pkg::*;
(
    input  wire logic        clk_sys_i,
    input  wire logic        sys_rst_i,
    input  wire logic [31:0] addr_i,
    input  wire logic [7:0]  wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [7:0]  rdata_o,
    output logic             irq_o,
    input  wire logic        channel_power_enable_i,
    input  wire logic        transmit_enable_bit_i,
    input  wire logic        receive_enable_bit_i,
    input  wire logic [1:0]  parity_mode_i,
    input  wire logic        external_baud_clock_in_i,
    input  wire logic        serial_rx_line_i,
    input  wire logic        rx_start_i,
    input  wire logic [7:0]  tx_data_i,
    input  wire logic [7:0]  rx_data_i,
    input  wire logic        rx_parity_bit_i,
    input  wire logic        rx_check_i,
    output logic             base_tick_o,
    output logic             filtered_rx_o,
    output logic             tx_bit_tick_o,
    output logic             rx_bit_tick_o,
    output logic             tx_div_tick_o,
    output logic             rx_div_tick_o,
    output logic             tx_parity_bit_o,
    output logic             tx_parity_en_o,
    output logic             parity_error_o
);

    typedef struct packed {
        logic [CSEL_W-1:0]  csel;
        logic [DIV_W-1:0]   div;
        logic [EVT_W-1:0]   status;
        logic [EVT_W-1:0]   mask;
        logic [7:0]         rdata;
        logic [PRESC_W-1:0] presc;
        logic               ext_prev;
        logic               base_tick;
        logic               samp;
        logic               filt;
        logic               tx_par;
        logic               tx_par_en;
        logic               par_err;
    } core_s;

    core_s        st;
    core_s        next_st;
    parity_mode_e mode;
    logic [PRESC_W-1:0] sel_mask;
    logic [EVT_W-1:0]   events;
    logic               rx_ones_odd;

    // ****************************************
    // Mode decode
    // ****************************************
    // The parity mode lives in the channel mode register outside this block
    assign mode        = decode_mode(parity_mode_i);
    assign rx_ones_odd = ones_odd(rx_data_i) ^ rx_parity_bit_i;

    // Prescaler tap mask: code n needs the low n bits all ones
    assign sel_mask = PRESC_W'((11'h001 << st.csel) - 11'h001);

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        next_st           = st;
        events            = '0;
        next_st.rdata     = 8'h00;
        next_st.base_tick = 1'b0;
        next_st.par_err   = 1'b0;

        // Prescaler and base clock; both held at rest while the channel is off
        next_st.ext_prev = external_baud_clock_in_i;
        if (!channel_power_enable_i) begin
            next_st.presc = '0;
        end else begin
            next_st.presc = st.presc + 10'h001;
            if (st.csel <= CSEL_MAX_DIV) begin
                next_st.base_tick = ((st.presc & sel_mask) == sel_mask);
            end else if (st.csel == CSEL_EXT) begin
                // External input is assumed synchronous; rising edge is the tick
                next_st.base_tick = external_baud_clock_in_i && !st.ext_prev;
            end
        end

        // Noise filter: sample each base tick, pass only repeated values
        if (st.base_tick) begin
            next_st.samp = serial_rx_line_i;
            if (serial_rx_line_i == st.samp) begin
                next_st.filt = serial_rx_line_i;
            end else if (st.samp != st.filt) begin
                events[EVT_NOISE] = 1'b1;
            end
        end

        // Transmit parity, registered so the shifter sees a stable bit
        case (mode)
            PAR_ZERO: begin
                next_st.tx_par    = 1'b0;
                next_st.tx_par_en = 1'b1;
            end
            PAR_ODD: begin
                next_st.tx_par    = ~ones_odd(tx_data_i);
                next_st.tx_par_en = 1'b1;
            end
            PAR_EVEN: begin
                next_st.tx_par    = ones_odd(tx_data_i);
                next_st.tx_par_en = 1'b1;
            end
            default: begin
                next_st.tx_par    = 1'b0;
                next_st.tx_par_en = 1'b0;
            end
        endcase

        // Receive parity check on the shifter's strobe
        if (rx_check_i) begin
            case (mode)
                PAR_ODD:  next_st.par_err = !rx_ones_odd;
                PAR_EVEN: next_st.par_err = rx_ones_odd;
                PAR_ZERO: next_st.par_err = 1'b0;
                default:  next_st.par_err = 1'b0;
            endcase
        end
        events[EVT_PARITY] = next_st.par_err;

        // Register writes; prohibited values are stored but reported
        if (wr_i) begin
            case (addr_i)
                CSEL_ADDR: begin
                    next_st.csel = wdata_i[CSEL_W-1:0];
                    events[EVT_BADCFG] = (wdata_i > 8'h0B);
                end
                DIV_ADDR: begin
                    next_st.div = wdata_i;
                    events[EVT_BADCFG] = (wdata_i < K_MIN);
                end
                MASK_ADDR: next_st.mask = wdata_i[EVT_W-1:0];
                default:   next_st.mask = st.mask;
            endcase
        end

        // Reads; status clears on read but a same-cycle event survives
        next_st.status = st.status | events;
        if (rd_i) begin
            case (addr_i)
                CSEL_ADDR:   next_st.rdata = {4'h0, st.csel};
                DIV_ADDR:    next_st.rdata = st.div;
                STATUS_ADDR: begin
                    next_st.rdata  = {5'h00, st.status};
                    next_st.status = events;
                end
                MASK_ADDR:   next_st.rdata = {5'h00, st.mask};
                default:     next_st.rdata = 8'h00;
            endcase
        end
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            st        <= '0;
            st.csel   <= CSEL_RESET;
            st.div    <= DIV_RESET;
            st.status <= STATUS_RESET;
            st.mask   <= MASK_RESET;
            st.samp   <= LINE_IDLE;
            st.filt   <= LINE_IDLE;
        end else begin
            st <= next_st;
        end
    end

    // ****************************************
    // Divider counters
    // ****************************************
    // Two counters so transmit and receive keep independent phase
    baud_divider_counter tx_counter (
        .clk_sys_i   (clk_sys_i),
        .sys_rst_i   (sys_rst_i),
        .run_i       (channel_power_enable_i && transmit_enable_bit_i),
        .restart_i   (1'b0),
        .base_tick_i (st.base_tick),
        .divisor_k_i (st.div),
        .div_tick_o  (tx_div_tick_o),
        .bit_tick_o  (tx_bit_tick_o)
    );

    baud_divider_counter rx_counter (
        .clk_sys_i   (clk_sys_i),
        .sys_rst_i   (sys_rst_i),
        .run_i       (channel_power_enable_i && receive_enable_bit_i),
        .restart_i   (rx_start_i),
        .base_tick_i (st.base_tick),
        .divisor_k_i (st.div),
        .div_tick_o  (rx_div_tick_o),
        .bit_tick_o  (rx_bit_tick_o)
    );

    // ****************************************
    // Outputs
    // ****************************************
    assign rdata_o         = st.rdata;
    assign irq_o           = |(st.status & st.mask);
    assign base_tick_o     = st.base_tick;
    assign filtered_rx_o   = st.filt;
    assign tx_parity_bit_o = st.tx_par;
    assign tx_parity_en_o  = st.tx_par_en;
    assign parity_error_o  = st.par_err;

    // ****************************************
    // Checks
    // ****************************************
    reset_values_a: assert property (@(posedge clk_sys_i)
        $fell(sys_rst_i) |-> (st.csel == CSEL_RESET) && (st.div == DIV_RESET))
        else $error("register reset values wrong");

    // The tick is registered, so it may legally return one cycle after enable comes back
    clock_gated_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        !channel_power_enable_i |=> !base_tick_o && !tx_div_tick_o && !rx_div_tick_o)
        else $error("base clock ran while channel disabled");

    ext_select_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (channel_power_enable_i && st.csel == CSEL_EXT
            && external_baud_clock_in_i && !st.ext_prev) |=> base_tick_o)
        else $error("external clock edge gave no base tick");

    odd_error_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (rx_check_i && mode == PAR_ODD) |=> parity_error_o == !$past(rx_ones_odd))
        else $error("odd parity check wrong");

    even_error_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (rx_check_i && mode == PAR_EVEN) |=> parity_error_o == $past(rx_ones_odd))
        else $error("even parity check wrong");

    zero_mode_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (mode == PAR_ZERO) |=> !tx_parity_bit_o && tx_parity_en_o && !parity_error_o)
        else $error("zero parity mode misbehaved");

    no_parity_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (mode == PAR_NONE) |=> !tx_parity_en_o && !parity_error_o)
        else $error("no-parity mode misbehaved");

    tx_total_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (mode == PAR_EVEN || mode == PAR_ODD) |=>
            ((ones_odd($past(tx_data_i)) ^ tx_parity_bit_o) == ($past(mode) == PAR_ODD)))
        else $error("transmit parity total wrong");

    filter_hold_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        !base_tick_o |=> $stable(filtered_rx_o))
        else $error("filter changed without base tick");

    filter_follow_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (base_tick_o && serial_rx_line_i == st.samp) |=> filtered_rx_o == $past(st.samp))
        else $error("filter missed two equal samples");

    // Status is sticky: only a status read or a mask write may drop the interrupt
    irq_sticky_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (irq_o && !(rd_i && addr_i == STATUS_ADDR) && !(wr_i && addr_i == MASK_ADDR))
            |=> irq_o)
        else $error("interrupt dropped while status unread");

    parity_cover_c: cover property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        parity_error_o);
    noise_cover_c: cover property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        st.status[EVT_NOISE]);
    rx_bit_cover_c: cover property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        rx_bit_tick_o);
    irq_cover_c: cover property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        irq_o);
    ext_tick_cover_c: cover property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        base_tick_o && st.csel == CSEL_EXT);

endmodule

//--- logic/uart_bpf_pkg.sv
// Package: constants, types and shared functions of the baud, parity and filter block
package uart_bpf_pkg;

    // ****************************************
    // Register map and reset values
    // ****************************************
    localparam logic [31:0] CSEL_ADDR     = 32'hFFFFFA06;
    localparam logic [31:0] DIV_ADDR      = 32'hFFFFFA07;
    localparam logic [31:0] STATUS_ADDR   = 32'hFFFFFA08;
    localparam logic [31:0] MASK_ADDR     = 32'hFFFFFA09;
    localparam logic [3:0]  CSEL_RESET    = 4'h0;
    localparam logic [7:0]  DIV_RESET     = 8'hFF;
    localparam logic [2:0]  STATUS_RESET  = 3'h0;
    localparam logic [2:0]  MASK_RESET    = 3'h0;

    // ****************************************
    // Field layouts and codes
    // ****************************************
    localparam int          CSEL_W        = 4;
    localparam int          DIV_W         = 8;
    localparam int          PRESC_W       = 10;
    localparam int          EVT_W         = 3;
    localparam int          EVT_PARITY    = 0;
    localparam int          EVT_BADCFG    = 1;
    localparam int          EVT_NOISE     = 2;
    localparam logic [3:0]  CSEL_MAX_DIV  = 4'hA;
    localparam logic [3:0]  CSEL_EXT      = 4'hB;
    localparam logic [7:0]  K_MIN         = 8'h08;
    localparam logic [1:0]  PAR_CODE_NONE = 2'h0;
    localparam logic [1:0]  PAR_CODE_ZERO = 2'h1;
    localparam logic [1:0]  PAR_CODE_ODD  = 2'h2;
    localparam logic [1:0]  PAR_CODE_EVEN = 2'h3;
    localparam logic        LINE_IDLE     = 1'b1;

    typedef enum logic [1:0] {
        PAR_NONE,
        PAR_ZERO,
        PAR_ODD,
        PAR_EVEN
    } parity_mode_e;

    // ****************************************
    // Shared functions
    // ****************************************
    // Count of ones is odd
    function automatic logic ones_odd(input logic [7:0] data);
        ones_odd = ^data;
    endfunction

    // Mode field code to mode
    function automatic parity_mode_e decode_mode(input logic [1:0] code);
        case (code)
            PAR_CODE_ZERO: decode_mode = PAR_ZERO;
            PAR_CODE_ODD:  decode_mode = PAR_ODD;
            PAR_CODE_EVEN: decode_mode = PAR_EVEN;
            default:       decode_mode = PAR_NONE;
        endcase
    endfunction

endpackage

//--- test/remote_serial_model.sv
// Remote serial device that drives the receive line of the channel
`timescale 1ns/100ps

module remote_serial_model (
    input  wire logic clk_sys_i,
    output logic      line_o
);

    // ****************************************
    // Line driver
    // ****************************************
    // Line rests high, as a pulled-up receive line does between frames
    initial line_o = 1'b1;

    // One level change, launched just after a clock edge, held until the next call
    task automatic drive(input logic v);
        @(posedge clk_sys_i);
        line_o <= v;
    endtask

endmodule

//--- test/testbench.sv
// Self-checking bench of the baud, parity and filter block
`timescale 1ns/100ps

module testbench
    import uart_bpf_pkg::*;
;

    // ****************************************
    // Stimulus and observed signals
    // ****************************************
    localparam int LIMIT = 5000;
    logic        clk_sys         = 1'b0;
    logic        sys_rst         = 1'b1;
    logic [31:0] addr            = '0;
    logic [7:0]  wdata           = '0;
    logic        wr              = 1'b0;
    logic        rd              = 1'b0;
    logic        ch_en           = 1'b0;
    logic        tx_en           = 1'b0;
    logic        rx_en           = 1'b0;
    logic [1:0]  par_mode        = '0;
    logic        ext_clk         = 1'b0;
    logic [2:0]  ext_cnt         = '0;
    logic        rx_start        = 1'b0;
    logic [7:0]  tx_data         = '0;
    logic [7:0]  rx_data         = '0;
    logic        rx_par          = 1'b0;
    logic        rx_check        = 1'b0;
    logic [7:0]  rdata;
    logic        irq;
    logic        rx_line;
    logic        filt;
    logic        tx_par;
    logic        tx_par_en;
    logic        par_err;
    wire  [4:0]  ticks;
    logic [5:0]  ev;
    logic [7:0]  pdat [3]        = '{8'h00, 8'h01, 8'hB7};
    int          error_cnt       = 0;
    int          samples_checked = 0;
    int          cyc             = 0;
    int          n;

    assign ev = {~filt, ticks};

    // Clock and a free-running external baud clock of eight system cycles
    initial forever #2 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        ext_cnt <= ext_cnt + 3'h1;
        ext_clk <= ext_cnt[2];
    end

    // Hang guard: a stuck wait ends the run as a failure
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            error_cnt++;
            results();
        end
    end

    uart_baud_parity_filter uart_baud_parity_filter_i (
        .clk_sys_i(clk_sys), .sys_rst_i(sys_rst), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .irq_o(irq),
        .channel_power_enable_i(ch_en), .transmit_enable_bit_i(tx_en),
        .receive_enable_bit_i(rx_en), .parity_mode_i(par_mode),
        .external_baud_clock_in_i(ext_clk), .serial_rx_line_i(rx_line),
        .rx_start_i(rx_start), .tx_data_i(tx_data), .rx_data_i(rx_data),
        .rx_parity_bit_i(rx_par), .rx_check_i(rx_check), .base_tick_o(ticks[0]),
        .filtered_rx_o(filt), .tx_div_tick_o(ticks[1]), .rx_div_tick_o(ticks[2]),
        .tx_bit_tick_o(ticks[3]), .rx_bit_tick_o(ticks[4]),
        .tx_parity_bit_o(tx_par), .tx_parity_en_o(tx_par_en), .parity_error_o(par_err)
    );

    remote_serial_model remote_serial_model_i (.clk_sys_i(clk_sys), .line_o(rx_line));

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [31:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk_sys);
        wr    <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so sample there
    task automatic rd_chk(input logic [31:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk_sys);
        rd   <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask

    task automatic set_en(input logic c, input logic t, input logic r);
        @(posedge clk_sys);
        ch_en <= c;
        tx_en <= t;
        rx_en <= r;
    endtask

    // Enables drop before the select and divisor change, then come back
    task automatic cfg(input logic [3:0] code, input logic [7:0] k);
        set_en(1'b0, 1'b0, 1'b0);
        wr_reg(CSEL_ADDR, {4'h0, code});
        wr_reg(DIV_ADDR, k);
        set_en(1'b1, 1'b1, 1'b1);
    endtask

    // Cycles until the chosen event is seen, capped so a dead output cannot hang
    task automatic wait_ev(input int sel);
        n = 0;
        do begin
            @(posedge clk_sys);
            #1;
            n++;
        end while (ev[sel] !== 1'b1 && n < 250);
    endtask

    // Steady spacing of a tick: skip to one pulse, then count to the next
    task automatic gap(input int sel, input int exp);
        wait_ev(sel);
        wait_ev(sel);
        chk(8'(n), 8'(exp));
    endtask

    task automatic base_cnt(input logic [7:0] exp);
        n = 0;
        repeat (20) begin
            @(posedge clk_sys);
            #1;
            if (ticks[0] === 1'b1) n++;
        end
        chk(8'(n), exp);
    endtask

    // One parity check and one transmit parity result, both one cycle later
    task automatic par_case(input logic [1:0] m, input logic [7:0] d, input logic p);
        logic eb;
        logic ee;
        eb = (m == 2'h3) ? ^d : (m == 2'h2) ? ~^d : 1'b0;
        ee = (m == 2'h3) ? ^{d, p} : (m == 2'h2) ? ~^{d, p} : 1'b0;
        @(posedge clk_sys);
        par_mode <= m;
        tx_data  <= d;
        rx_data  <= d;
        rx_par   <= p;
        rx_check <= 1'b1;
        @(posedge clk_sys);
        rx_check <= 1'b0;
        #1;
        chk({7'h00, par_err}, {7'h00, ee});
        chk({7'h00, tx_par_en}, {7'h00, m != 2'h0});
        if (m != 2'h0) chk({7'h00, tx_par}, {7'h00, eb});
    endtask

    task automatic results();
        $display("checks=%0d errors=%0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        repeat (6) @(posedge clk_sys);
        sys_rst <= 1'b0;
        rd_chk(CSEL_ADDR, 8'h00);
        rd_chk(DIV_ADDR, 8'hFF);
        rd_chk(32'hFFFFFA0A, 8'h00);
        // Unmasked parity event raises the interrupt until status is read
        wr_reg(MASK_ADDR, 8'h01);
        par_case(2'h2, 8'h00, 1'b0);
        chk({7'h00, irq}, 8'h01);
        rd_chk(STATUS_ADDR, 8'h01);
        chk({7'h00, irq}, 8'h00);
        wr_reg(MASK_ADDR, 8'h00);
        // Filter: one-tick glitch rejected, held level passes within the lag
        set_en(1'b1, 1'b0, 1'b0);
        repeat (4) @(posedge clk_sys);
        remote_serial_model_i.drive(1'b0);
        remote_serial_model_i.drive(1'b1);
        repeat (4) @(posedge clk_sys);
        #1;
        chk({7'h00, filt}, 8'h01);
        rd_chk(STATUS_ADDR, 8'h04);
        remote_serial_model_i.drive(1'b0);
        wait_ev(5);
        chk(8'(n >= 2 && n <= 4), 8'h01);
        remote_serial_model_i.drive(1'b1);
        // Prescaler codes and both dividers, with bit rate at half the divider rate
        for (int c = 0; c < 3; c++) begin
            cfg(4'(c), 8'(8 + c));
            gap(0, 1 << c);
            gap(1, (8 + c) << c);
            gap(2, (8 + c) << c);
            gap(3, (16 + 2 * c) << c);
            gap(4, (16 + 2 * c) << c);
        end
        cfg(CSEL_EXT, 8'h08);
        gap(0, 8);
        // Receive phase restarts on a start bit
        cfg(4'h0, 8'h08);
        @(posedge clk_sys);
        rx_start <= 1'b1;
        @(posedge clk_sys);
        rx_start <= 1'b0;
        wait_ev(4);
        chk(8'(n >= 15 && n <= 18), 8'h01);
        // Prohibited settings are stored and reported, and give no base clock
        set_en(1'b0, 1'b0, 1'b0);
        base_cnt(8'h00);
        wr_reg(CSEL_ADDR, 8'h0C);
        wr_reg(DIV_ADDR, 8'h07);
        rd_chk(CSEL_ADDR, 8'h0C);
        rd_chk(DIV_ADDR, 8'h07);
        rd_chk(STATUS_ADDR, 8'h02);
        set_en(1'b1, 1'b0, 1'b0);
        base_cnt(8'h00);
        // Every parity mode over a few data and parity values, interrupt masked
        for (int m = 0; m < 4; m++) begin
            for (int i = 0; i < 3; i++) begin
                par_case(2'(m), pdat[i], 1'b0);
                par_case(2'(m), pdat[i], 1'b1);
            end
        end
        chk({7'h00, irq}, 8'h00);
        rd_chk(STATUS_ADDR, 8'h01);
        results();
    end

endmodule
